//--- hdl/rsw_bbm.sv
// break-before-make sequencer driving the sixteen changeover relays
`timescale 1ns/1ps
module rsw_bbm import rsw_pkg::*; #(
	parameter int N_CHAN  = RSW_NUM_CHAN,
	parameter int GAP_CYC = RSW_BBM_CYC
) (
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	input  wire logic [N_CHAN-1:0] target,
	output rsw_relay_t             relay
);

	// ********************************************************
	// state
	// ********************************************************
	typedef struct packed {
		logic [N_CHAN-1:0]    applied;
		logic [N_CHAN-1:0]    no;
		logic [N_CHAN-1:0]    nc;
		logic [RSW_GAP_W-1:0] cnt;
	} rsw_bbm_st_t;

	rsw_bbm_st_t st;
	rsw_bbm_st_t next_st;
	logic [N_CHAN-1:0] diff;

	assign diff = target ^ st.applied;

	// a changed channel drops both contacts, then makes the new one
	// after the gap; a new change restarts the gap for all pending
	always_comb begin
		next_st = st;
		if (diff != '0) begin
			next_st.no      = st.no & ~diff; // [RULE_02]
			next_st.nc      = st.nc & ~diff; // [RULE_02]
			next_st.applied = target;
			next_st.cnt     = RSW_GAP_W'(GAP_CYC);
		end else if (st.cnt != '0) begin
			next_st.cnt = st.cnt - 1'b1;
			if (st.cnt == RSW_GAP_W'(1)) begin
				next_st.no = st.applied;
				next_st.nc = ~st.applied; // [RULE_01]
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st.applied <= '0;
			st.no      <= '0;
			st.nc      <= '1; // [RULE_01]
			st.cnt     <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign relay.make_no = st.no;
	assign relay.make_nc = st.nc;

	// ********************************************************
	// checks
	// ********************************************************
	property p_bbm_no_overlap;
		@(posedge sys_clk) disable iff (sys_rst)
		((st.no & $past(st.nc)) == '0) && ((st.nc & $past(st.no)) == '0);
	endproperty
	a_bbm_no_overlap: assert property (p_bbm_no_overlap) // [RULE_02]
		else $error("contact made while the other was still made");

	property p_settled_state;
		@(posedge sys_clk) disable iff (sys_rst)
		(st.cnt == '0 && diff == '0) |-> (st.nc == ~target && st.no == target);
	endproperty
	a_settled_state: assert property (p_settled_state) // [RULE_01]
		else $error("settled relays differ from commanded state");

endmodule

//--- hdl/rsw_top.sv
// register control of the sixteen channel relay switch card
// Function
// RULE_01: reset or open returns relay to normally closed
// RULE_02: changeover breaks old contact before making new
// RULE_03: identification read drives low eight data bits
// RULE_04: identification is module code over terminal code
// RULE_05: missing terminal module forces low bits high
// RULE_06: register one reads a fixed constant
// RULE_07: register three reads last programmed channel state
// RULE_08: controller treats readback as signed word
// RULE_09: any write to register zero opens all
// RULE_10: that write equals the backplane accessory reset
// RULE_11: register three write sets channels, one closes
// RULE_12: controller writes command as signed word
// RULE_13: channel state reads zero after accessory reset
// RULE_14: unused registers ignore writes, read zero
`timescale 1ns/1ps
module rsw_top import rsw_pkg::*; #(
	parameter int         N_CHAN    = RSW_NUM_CHAN,
	parameter int         GAP_CYC   = RSW_BBM_CYC,
	parameter logic [4:0] COMP_CODE = RSW_COMP_CODE,
	parameter logic [15:0] CONST_WD = RSW_CONST_WORD
) (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  rsw_bus_req_t    bus_req,
	input  wire logic       acc_reset,
	input  wire logic [2:0] term_code,
	input  wire logic       term_present,
	output rsw_bus_rsp_t    bus_rsp,
	output rsw_relay_t      relay
);

	// ********************************************************
	// helpers
	// ********************************************************
	function automatic logic hit(input logic strobe,
		input logic [1:0] addr, input logic [1:0] ofs);
		hit = strobe && (addr == ofs);
	endfunction

	function automatic logic [15:0] ident_word(input logic [4:0] comp,
		input logic [2:0] term, input logic present);
		logic [2:0] t;
		t = present ? term : RSW_TERM_ABSENT; // [RULE_05]
		ident_word = {8'h00, comp, t}; // [RULE_03] [RULE_04]
	endfunction

	// ********************************************************
	// state
	// ********************************************************
	typedef struct packed {
		logic [15:0] cmd;
		logic [15:0] rdata;
		logic        rvalid;
	} rsw_top_st_t;

	rsw_top_st_t st;
	rsw_top_st_t next_st;

	logic wr_reset;
	logic wr_chan;
	logic any_reset;

	assign wr_reset  = hit(bus_req.wr, bus_req.addr, RSW_OFS_RESET);
	assign wr_chan   = hit(bus_req.wr, bus_req.addr, RSW_OFS_CHAN);
	// write data of reset is ignored, only the strobe matters
	assign any_reset = wr_reset || acc_reset; // [RULE_09] [RULE_10]

	// ********************************************************
	// register access
	// ********************************************************
	always_comb begin
		next_st        = st;
		next_st.rvalid = bus_req.rd;
		if (bus_req.rd) begin
			case (bus_req.addr)
				RSW_OFS_IDENT: begin
					next_st.rdata = ident_word(COMP_CODE, term_code,
						term_present); // [RULE_03]
				end
				RSW_OFS_CONST: begin
					next_st.rdata = CONST_WD; // [RULE_06]
				end
				RSW_OFS_CHAN: begin
					// raw bits; signed view is up to the controller
					next_st.rdata = st.cmd; // [RULE_07] [RULE_08]
				end
				default: begin
					next_st.rdata = RSW_RD_ZERO; // [RULE_14]
				end
			endcase
		end
		// reset wins over a channel write in the same cycle
		if (any_reset) begin
			next_st.cmd = RSW_CHAN_RESET; // [RULE_09] [RULE_13]
		end else if (wr_chan) begin
			next_st.cmd = bus_req.wdata; // [RULE_11] [RULE_12]
		end
		// writes to offsets one and two fall through untouched [RULE_14]
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st.cmd    <= RSW_CHAN_RESET;
			st.rdata  <= RSW_RD_ZERO;
			st.rvalid <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign bus_rsp.rvalid = st.rvalid;
	assign bus_rsp.rdata  = st.rdata;

	// ********************************************************
	// relay drive
	// ********************************************************
	// a zero command bit leaves the relay unpowered on its nc contact
	rsw_bbm #(
		.N_CHAN  (N_CHAN),
		.GAP_CYC (GAP_CYC)
	) u_bbm (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.target  (st.cmd[N_CHAN-1:0]), // [RULE_01] [RULE_02]
		.relay   (relay)
	);

	// ********************************************************
	// checks
	// ********************************************************
	sequence s_rd(logic [1:0] ofs);
		bus_req.rd && bus_req.addr == ofs;
	endsequence

	sequence s_acc_rst;
		any_reset;
	endsequence

	sequence s_quiet;
		!bus_req.wr && !acc_reset;
	endsequence

	property p_id_read;
		@(posedge sys_clk) disable iff (sys_rst)
		s_rd(RSW_OFS_IDENT) |=> bus_rsp.rvalid
			&& bus_rsp.rdata[15:8] == 8'h00
			&& bus_rsp.rdata[7:3] == COMP_CODE;
	endproperty
	a_id_read: assert property (p_id_read) // [RULE_03]
		else $error("identification read returned wrong byte");

	property p_id_term;
		@(posedge sys_clk) disable iff (sys_rst)
		(s_rd(RSW_OFS_IDENT) ##0 term_present) |=>
			bus_rsp.rdata[2:0] == $past(term_code);
	endproperty
	a_id_term: assert property (p_id_term) // [RULE_04]
		else $error("terminal field does not follow terminal code");

	property p_id_absent;
		@(posedge sys_clk) disable iff (sys_rst)
		(s_rd(RSW_OFS_IDENT) ##0 !term_present) |=>
			bus_rsp.rdata[2:0] == RSW_TERM_ABSENT;
	endproperty
	a_id_absent: assert property (p_id_absent) // [RULE_05]
		else $error("absent terminal not reported as all ones");

	property p_const_read;
		@(posedge sys_clk) disable iff (sys_rst)
		s_rd(RSW_OFS_CONST) |=> bus_rsp.rdata == CONST_WD;
	endproperty
	a_const_read: assert property (p_const_read) // [RULE_06]
		else $error("constant register changed value");

	property p_chan_read;
		@(posedge sys_clk) disable iff (sys_rst)
		s_rd(RSW_OFS_CHAN) |=> bus_rsp.rdata == $past(st.cmd);
	endproperty
	a_chan_read: assert property (p_chan_read) // [RULE_07]
		else $error("channel readback differs from command");

	property p_wr_reset;
		@(posedge sys_clk) disable iff (sys_rst)
		wr_reset |=> st.cmd == RSW_CHAN_RESET;
	endproperty
	a_wr_reset: assert property (p_wr_reset) // [RULE_09]
		else $error("reset write left a channel closed");

	property p_acc_reset;
		@(posedge sys_clk) disable iff (sys_rst)
		acc_reset |=> st.cmd == RSW_CHAN_RESET;
	endproperty
	a_acc_reset: assert property (p_acc_reset) // [RULE_10]
		else $error("accessory reset left a channel closed");

	property p_chan_write;
		@(posedge sys_clk) disable iff (sys_rst)
		(wr_chan && !any_reset) |=> st.cmd == $past(bus_req.wdata);
	endproperty
	a_chan_write: assert property (p_chan_write) // [RULE_11]
		else $error("channel write not loaded");

	property p_reset_readback;
		@(posedge sys_clk) disable iff (sys_rst)
		(s_acc_rst ##1 (s_rd(RSW_OFS_CHAN) ##0 !bus_req.wr)) |=>
			bus_rsp.rdata == RSW_CHAN_RESET;
	endproperty
	a_reset_readback: assert property (p_reset_readback) // [RULE_13]
		else $error("channel state not zero after reset");

	property p_ignored_write;
		@(posedge sys_clk) disable iff (sys_rst)
		(bus_req.wr && !acc_reset && (bus_req.addr == RSW_OFS_CONST
			|| bus_req.addr == RSW_OFS_UNUSED)) |=> $stable(st.cmd);
	endproperty
	a_ignored_write: assert property (p_ignored_write) // [RULE_14]
		else $error("write to unused register changed state");

	property p_unused_read;
		@(posedge sys_clk) disable iff (sys_rst)
		s_rd(RSW_OFS_UNUSED) |=> bus_rsp.rdata == RSW_RD_ZERO;
	endproperty
	a_unused_read: assert property (p_unused_read) // [RULE_14]
		else $error("unused register read not zero");

	property p_open_drops_no;
		@(posedge sys_clk) disable iff (sys_rst)
		any_reset |=> ##1 relay.make_no == '0;
	endproperty
	a_open_drops_no: assert property (p_open_drops_no) // [RULE_01]
		else $error("normally open contact held after reset");

	// exactly one cycle of latency; the controller counts on it
	property p_rd_answer;
		@(posedge sys_clk) disable iff (sys_rst)
		bus_req.rd |=> bus_rsp.rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) // [RULE_07]
		else $error("read strobe got no answer");

	// an answer with no read would let the controller take stale data
	property p_no_answer;
		@(posedge sys_clk) disable iff (sys_rst)
		!bus_req.rd |=> !bus_rsp.rvalid;
	endproperty
	a_no_answer: assert property (p_no_answer) // [RULE_14]
		else $error("answer given without a read");

	property p_rdata_stands;
		@(posedge sys_clk) disable iff (sys_rst)
		!bus_req.rd |=> $stable(bus_rsp.rdata);
	endproperty
	a_rdata_stands: assert property (p_rdata_stands) // [RULE_07]
		else $error("read data moved without a read");

	// reset clears the command word only, the last answer stays
	property p_reset_keeps_rdata;
		@(posedge sys_clk) disable iff (sys_rst)
		(any_reset && !bus_req.rd) |=> $stable(bus_rsp.rdata);
	endproperty
	a_reset_keeps_rdata: assert property (p_reset_keeps_rdata) // [RULE_10]
		else $error("reset disturbed the read data");

	property p_cmd_stands;
		@(posedge sys_clk) disable iff (sys_rst)
		s_quiet |=> $stable(st.cmd);
	endproperty
	a_cmd_stands: assert property (p_cmd_stands) // [RULE_11]
		else $error("channel command moved without a write");

	// offset zero is shared; only a write there may reset
	property p_read_no_effect;
		@(posedge sys_clk) disable iff (sys_rst)
		(s_rd(RSW_OFS_IDENT) ##0 s_quiet) |=> $stable(st.cmd);
	endproperty
	a_read_no_effect: assert property (p_read_no_effect) // [RULE_09]
		else $error("identification read changed the channels");

	// both throws made at once would short the common to both sides
	property p_contacts_apart;
		@(posedge sys_clk) disable iff (sys_rst)
		(relay.make_no & relay.make_nc) == '0;
	endproperty
	a_contacts_apart: assert property (p_contacts_apart) // [RULE_02]
		else $error("both contacts of a channel made at once");

	// the relays drop changed contacts one cycle after the command word changes
	property p_no_only_closed;
		@(posedge sys_clk) disable iff (sys_rst)
		(relay.make_no & ~$past(st.cmd)) == '0;
	endproperty
	a_no_only_closed: assert property (p_no_only_closed) // [RULE_11]
		else $error("open contact made on a channel left open");

	property p_nc_only_open;
		@(posedge sys_clk) disable iff (sys_rst)
		(relay.make_nc & $past(st.cmd)) == '0;
	endproperty
	a_nc_only_open: assert property (p_nc_only_open) // [RULE_01]
		else $error("closed contact made on a channel commanded closed");

endmodule

//--- pkg/rsw_pkg.sv
// package: register map, field layout, timing and carrier types of the switch
package rsw_pkg;

	// ********************************************************
	// register offsets
	// ********************************************************
	localparam logic [1:0] RSW_OFS_IDENT   = 2'h0;
	localparam logic [1:0] RSW_OFS_RESET   = 2'h0;
	localparam logic [1:0] RSW_OFS_CONST   = 2'h1;
	localparam logic [1:0] RSW_OFS_UNUSED  = 2'h2;
	localparam logic [1:0] RSW_OFS_CHAN    = 2'h3;

	// ********************************************************
	// field layout and values
	// ********************************************************
	localparam int         RSW_NUM_CHAN    = 16;
	localparam int         RSW_DATA_W      = 16;
	localparam int         RSW_ID_W        = 8;
	localparam int         RSW_COMP_W      = 5;
	localparam int         RSW_TERM_W      = 3;
	localparam int         RSW_TERM_LSB    = 0;
	localparam int         RSW_COMP_LSB    = 3;
	localparam logic [2:0] RSW_TERM_ABSENT = 3'h7;
	localparam logic [15:0] RSW_CHAN_RESET = 16'h0000;
	localparam logic [15:0] RSW_RD_ZERO    = 16'h0000;
	// arbitrary identification values, not those of any real part
	localparam logic [4:0]  RSW_COMP_CODE  = 5'h15;
	localparam logic [15:0] RSW_CONST_WORD = 16'hA5C3;

	// ********************************************************
	// timing
	// ********************************************************
	localparam int RSW_CLK_NS     = 40;
	localparam int RSW_BBM_GAP_NS = 10000;
	localparam int RSW_BBM_CYC    =
		(RSW_BBM_GAP_NS + RSW_CLK_NS - 1) / RSW_CLK_NS;
	localparam int RSW_GAP_W      = 9;

	// ********************************************************
	// carriers
	// ********************************************************
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [1:0]  addr;
		logic [15:0] wdata;
	} rsw_bus_req_t;

	typedef struct packed {
		logic        rvalid;
		logic [15:0] rdata;
	} rsw_bus_rsp_t;

	typedef struct packed {
		logic [15:0] make_no;
		logic [15:0] make_nc;
	} rsw_relay_t;

endpackage

//--- test/rsw_ctl_model.sv
// backplane controller model that issues register reads and writes
`timescale 1ns/1ps
module rsw_ctl_model import rsw_pkg::*; (
	input  wire logic   sys_clk,
	input  rsw_bus_rsp_t bus_rsp,
	output rsw_bus_req_t bus_req
);
	// ********************************************************
	// bus cycles
	// ********************************************************
	initial begin
		bus_req = '0;
	end

	// raw bits only; a signed reading is the caller's business
	task automatic reg_write(input logic [1:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		bus_req.wr    <= 1'b1;
		bus_req.addr  <= a;
		bus_req.wdata <= d;
		@(posedge sys_clk);
		bus_req.wr    <= 1'b0;
		// released lines show junk so stale values never look valid
		bus_req.addr  <= ~a;
		bus_req.wdata <= ~d;
	endtask

	task automatic reg_read(input logic [1:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		bus_req.rd   <= 1'b1;
		bus_req.addr <= a;
		@(posedge sys_clk);
		bus_req.rd   <= 1'b0;
		bus_req.addr <= ~a;
		@(posedge sys_clk);
		d = (bus_rsp.rvalid === 1'b1) ? bus_rsp.rdata : 16'hXXXX;
	endtask
endmodule

//--- test/tb_top.sv
// testbench of the relay switch register control
`timescale 1ns/1ps
module tb_top import rsw_pkg::*; ;
	localparam int GAP = 4;
	logic         sys_clk;
	logic         sys_rst;
	logic         acc_reset;
	logic         term_present;
	logic [2:0]   term_code;
	rsw_bus_req_t bus_req;
	rsw_bus_rsp_t bus_rsp;
	rsw_relay_t   relay;
	int           errors;
	int           n_checks;
	int           i;
	logic [15:0]  rd_v;

	// ********************************************************
	// instances
	// ********************************************************
	rsw_top #(.GAP_CYC(GAP)) u_dut (
		.sys_clk      (sys_clk),
		.sys_rst      (sys_rst),
		.bus_req      (bus_req),
		.acc_reset    (acc_reset),
		.term_code    (term_code),
		.term_present (term_present),
		.bus_rsp      (bus_rsp),
		.relay        (relay)
	);

	rsw_ctl_model u_ctl (
		.sys_clk (sys_clk),
		.bus_rsp (bus_rsp),
		.bus_req (bus_req)
	);

	// ********************************************************
	// helpers
	// ********************************************************
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	task automatic rd_chk(input logic [1:0] a, input logic [15:0] exp);
		u_ctl.reg_read(a, rd_v);
		chk(exp, rd_v);
	endtask

	// waits for the gap to pass, noting whether changed bits ever broke
	task automatic relay_wait(input logic [15:0] w, input logic [15:0] pv);
		logic brk;
		int   k;
		brk = (w == pv);
		for (k = 0; k < 40; k++) begin
			@(posedge sys_clk);
			#1;
			if (((relay.make_no | relay.make_nc) & (w ^ pv)) == 16'h0000)
				brk = 1'b1;
			if (brk && relay.make_no === w && relay.make_nc === ~w)
				break;
		end
		chk(16'h0001, {15'h0000, brk});
		chk(w, relay.make_no);
		chk(~w, relay.make_nc);
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ********************************************************
	// tests
	// ********************************************************
	initial begin
		errors = 0;
		n_checks = 0;
		sys_rst = 1'b1;
		acc_reset = 1'b0;
		term_present = 1'b1;
		term_code = 3'h2;
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;

		rd_chk(2'h3, 16'h0000);
		relay_wait(16'h0000, 16'h0000);
		$display("test reset_state done");

		for (i = 0; i < 8; i++) begin
			@(posedge sys_clk);
			term_code <= i[2:0];
			rd_chk(2'h0, {8'h00, RSW_COMP_CODE, i[2:0]});
		end
		@(posedge sys_clk);
		term_present <= 1'b0;
		term_code <= 3'h1;
		rd_chk(2'h0, {8'h00, RSW_COMP_CODE, 3'h7});
		$display("test ident done");

		u_ctl.reg_write(2'h3, 16'h8001);
		relay_wait(16'h8001, 16'h0000);
		rd_chk(2'h3, 16'h8001);
		u_ctl.reg_write(2'h1, 16'h0000);
		u_ctl.reg_write(2'h2, 16'hFFFF);
		rd_chk(2'h1, RSW_CONST_WORD);
		rd_chk(2'h2, 16'h0000);
		rd_chk(2'h3, 16'h8001);
		$display("test registers done");

		// every channel flips, so every bit must break first
		u_ctl.reg_write(2'h3, 16'h7FFE);
		relay_wait(16'h7FFE, 16'h8001);
		rd_chk(2'h3, 16'h7FFE);
		u_ctl.reg_write(2'h0, 16'hFFFF);
		relay_wait(16'h0000, 16'h7FFE);
		rd_chk(2'h3, 16'h0000);
		$display("test reset_write done");

		u_ctl.reg_write(2'h3, 16'hC3A5);
		relay_wait(16'hC3A5, 16'h0000);
		@(posedge sys_clk);
		acc_reset <= 1'b1;
		// read in the very cycle after the reset is first taken
		rd_chk(2'h3, 16'h0000);
		acc_reset <= 1'b0;
		relay_wait(16'h0000, 16'hC3A5);
		rd_chk(2'h3, 16'h0000);
		$display("test acc_reset done");

		complete_run();
	end

	// watchdog, far beyond the hundred or so cycles the tests need
	initial begin
		#400000;
		errors++;
		complete_run();
	end
endmodule
